// [design/pfc_rail_pid_loops.sv]
// Purpose: rail voltage loop feeding the inner current loop of the rectifier
// Assumes: samples arrive from logic on i_sys_clk with a one-cycle strobe
// Notes:   one evaluation per sample period; a missed sample is flagged
`timescale 1ns/1ns
module pfc_rail_pid_loops
    import pfc_loop_pkg::*;
#(
    parameter int unsigned SAMPLE_PERIOD_CYC = SAMPLE_CYCLES  // period count
)
(
    input  wire logic  i_sys_clk,       // system clock, 100 MHz
    input  wire logic  i_sys_rst,       // sync reset, high
    input  wire logic  i_sample_valid,  // sample strobe, one cycle
    input  wire samp_t i_rail_sample,   // positive rail voltage, Q1.15
    input  wire samp_t i_line_sample,   // AC line voltage, Q1.15
    input  wire samp_t i_cur_sample,    // inductor current, Q1.15
    input  wire samp_t i_rail_setpoint, // rail voltage setpoint, Q1.15
    output samp_t      o_duty,          // duty command
    output logic       o_duty_valid,    // duty update pulse
    output logic       o_sample_late,   // period began without fresh samples
    output acc_t       o_rail_ctrl      // rail compensator output
);

    typedef struct packed {
        loop_st_t   st;
        logic [15:0] cnt;
        samp_t      rail;
        samp_t      line;
        samp_t      cur;
        logic       fresh;
        logic       late;
        acc_t       filt;
        acc_t       rail_err;
        acc_t       iset;
        acc_t       cur_err;
        samp_t      duty;
        logic       duty_vld;
        logic       start_v;
        logic       start_i;
    } loop_state_t;

    loop_state_t s_r;
    loop_state_t s_nxt;

    acc_t rail_out;
    logic rail_done;
    acc_t cur_out;
    logic cur_done;

    pid_core u_rail_pi (
        .i_sys_clk (i_sys_clk),
        .i_sys_rst (i_sys_rst),
        .i_start   (s_r.start_v),
        .i_err     (s_r.rail_err),
        .i_kp      (KP_RAIL),
        .i_ki      (KI_RAIL),
        .i_kd      (KD_RAIL),
        .o_out     (rail_out),
        .o_done    (rail_done)
    );

    pid_core u_cur_pi (
        .i_sys_clk (i_sys_clk),
        .i_sys_rst (i_sys_rst),
        .i_start   (s_r.start_i),
        .i_err     (s_r.cur_err),
        .i_kp      (KP_CUR),
        .i_ki      (KI_CUR),
        .i_kd      (KD_CUR),
        .o_out     (cur_out),
        .o_done    (cur_done)
    );

    always_comb
    begin
        logic  tick;
        samp_t line_abs;
        wide_t prod;
        s_nxt          = s_r;
        s_nxt.duty_vld = 1'b0;
        s_nxt.start_v  = 1'b0;
        s_nxt.start_i  = 1'b0;
        tick           = 1'b0;
        line_abs       = '0;
        prod           = '0;

        // sample period counter
        if (s_r.cnt == 16'(SAMPLE_PERIOD_CYC - 1))
        begin
            s_nxt.cnt = 16'h0000;
            tick      = 1'b1;
        end
        else
        begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
        end

        // capture samples from the source
        if (i_sample_valid)
        begin
            s_nxt.rail  = i_rail_sample;
            s_nxt.line  = i_line_sample;
            s_nxt.cur   = i_cur_sample;
            s_nxt.fresh = 1'b1;
        end

        unique case (s_r.st)
            ST_IDLE:
            begin
                if (tick)
                begin
                    if (s_r.fresh)
                    begin
                        s_nxt.late  = 1'b0;
                        s_nxt.fresh = i_sample_valid;
                        s_nxt.st    = ST_FILT;
                    end
                    else
                    begin
                        s_nxt.late = 1'b1;
                    end
                end
            end
            ST_FILT:
            begin
                s_nxt.filt = sat32(
                    (mul32(acc_t'(LPF_B0), acc_t'(s_r.rail))
                   + mul32(acc_t'(LPF_A1), s_r.filt)) >>> GAIN_FRAC);
                s_nxt.st   = ST_RERR;
            end
            ST_RERR:
            begin
                s_nxt.rail_err = sat32(wide_t'(i_rail_setpoint)
                                     - wide_t'(s_r.filt));
                s_nxt.start_v  = 1'b1;
                s_nxt.st       = ST_RPI;
            end
            ST_RPI:
            begin
                if (rail_done)
                begin
                    // abs of the most negative code saturates
                    if (s_r.line == 16'sh8000)
                        line_abs = SAMP_MAX;
                    else if (s_r.line < 16'sh0000)
                        line_abs = -s_r.line;
                    else
                        line_abs = s_r.line;
                    prod       = mul32(rail_out, acc_t'(line_abs));
                    s_nxt.iset = sat32(prod >>> SAMP_FRAC);
                    s_nxt.st   = ST_CERR;
                end
            end
            ST_CERR:
            begin
                s_nxt.cur_err = sat32(wide_t'(s_r.iset)
                                    - wide_t'(s_r.cur));
                s_nxt.start_i = 1'b1;
                s_nxt.st      = ST_CPI;
            end
            ST_CPI:
            begin
                if (cur_done)
                begin
                    if (cur_out > acc_t'(DUTY_MAX))
                        s_nxt.duty = DUTY_MAX;
                    else if (cur_out < acc_t'(DUTY_MIN))
                        s_nxt.duty = DUTY_MIN;
                    else
                        s_nxt.duty = cur_out[15:0];
                    s_nxt.duty_vld = 1'b1;
                    s_nxt.st       = ST_IDLE;
                end
            end
            default:
            begin
                s_nxt.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            s_r    <= '0;
            s_r.st <= ST_IDLE;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign o_duty        = s_r.duty;
    assign o_duty_valid  = s_r.duty_vld;
    assign o_sample_late = s_r.late;
    assign o_rail_ctrl   = rail_out;

endmodule : pfc_rail_pid_loops

// [design/pfc_loop_pkg.sv]
// Purpose: constants, types and helpers for the rail and current loops
// Assumes: 100 MHz system clock, loops run at the 20 kHz sample rate
// Notes:   gains are signed Q4.12, samples signed Q1.15
//
// What this block does
// - every gain constant is a 16-bit fixed-point value
// - every stored accumulator, integral sum included, is 32 bits wide; the PID product sum acc is 64 bits
// - output = kp*error + ki*error sum + kd*(error - previous error)
// - ki = kp*ts/ti, kd = kp*td/ts, kp used unchanged
// - rail error compares sensed positive rail against the voltage setpoint
// - rail path is low-pass filtered to reject line-frequency ripple
// - filter: new output = b0*input + a1*previous output
// - rail compensator is a PI stage with its given gains
// - current setpoint = rail compensator output times line sample
// - current loop uses the absolute value of the line sample
// - current compensator is a PI stage with its given gains
// - loops are evaluated once per system sample period
package pfc_loop_pkg;

    localparam int unsigned CLK_HZ         = 100_000_000;
    localparam int unsigned SAMPLE_RATE_HZ = 20_000;
    localparam int unsigned SAMPLE_CYCLES  = CLK_HZ / SAMPLE_RATE_HZ;
    localparam int unsigned TS_NS          = 1_000_000_000 / SAMPLE_RATE_HZ;

    localparam int unsigned GAIN_FRAC = 12;
    localparam int unsigned SAMP_FRAC = 15;

    // analog parameters: gains in Q4.12, times in ns
    localparam int KP_RAIL_Q   = 3686;        // 0.9
    localparam int TI_RAIL_NS  = 56_300_000;  // 0.0563 s
    localparam int TD_RAIL_NS  = 0;
    localparam int KP_CUR_Q    = 26214;       // 6.4
    localparam int TI_CUR_NS   = 200_000;     // 0.0002 s
    localparam int TD_CUR_NS   = 0;

    typedef logic signed [15:0] gain_t;
    typedef logic signed [15:0] samp_t;
    typedef logic signed [31:0] acc_t;
    typedef logic signed [63:0] wide_t;

    // discrete gains derived from the analog ones
    localparam gain_t KP_RAIL = gain_t'(KP_RAIL_Q);
    localparam gain_t KI_RAIL =
        gain_t'(longint'(KP_RAIL_Q) * TS_NS / TI_RAIL_NS);
    localparam gain_t KD_RAIL =
        gain_t'(longint'(KP_RAIL_Q) * TD_RAIL_NS / TS_NS);
    localparam gain_t KP_CUR  = gain_t'(KP_CUR_Q);
    localparam gain_t KI_CUR  =
        gain_t'(longint'(KP_CUR_Q) * TS_NS / TI_CUR_NS);
    localparam gain_t KD_CUR  =
        gain_t'(longint'(KP_CUR_Q) * TD_CUR_NS / TS_NS);

    // low-pass coefficients, Q4.12: 0.01 and 0.9984
    localparam gain_t LPF_B0 = 16'sh0029;
    localparam gain_t LPF_A1 = 16'sh0FF9;

    localparam samp_t DUTY_MIN = 16'sh0000;
    localparam samp_t DUTY_MAX = 16'sh7FFF;
    localparam samp_t SAMP_MAX = 16'sh7FFF;
    localparam acc_t  ACC_MAX  = 32'sh7FFFFFFF;
    localparam acc_t  ACC_MIN  = 32'sh80000000;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_FILT = 3'h1,
        ST_RERR = 3'h3,
        ST_RPI  = 3'h2,
        ST_CERR = 3'h6,
        ST_CPI  = 3'h7
    } loop_st_t;

    function automatic acc_t sat32(input wide_t v);
        if (v > wide_t'(ACC_MAX))
            return ACC_MAX;
        else if (v < wide_t'(ACC_MIN))
            return ACC_MIN;
        else
            return v[31:0];
    endfunction : sat32

    function automatic wide_t mul32(input acc_t a, input acc_t b);
        wide_t ea;
        wide_t eb;
        ea = wide_t'(a);
        eb = wide_t'(b);
        return ea * eb;
    endfunction : mul32

endpackage : pfc_loop_pkg

// [design/pid_core.sv]
// Purpose: one PID/PI compensator step per start pulse
// Assumes: gains Q4.12, error and output 32-bit signed
// Notes:   result and done appear one cycle after start
`timescale 1ns/1ns
module pid_core
    import pfc_loop_pkg::*;
(
    input  wire logic  i_sys_clk,  // system clock
    input  wire logic  i_sys_rst,  // sync reset, high
    input  wire logic  i_start,    // evaluate one step
    input  wire acc_t  i_err,      // current error
    input  wire gain_t i_kp,       // proportional gain
    input  wire gain_t i_ki,       // integral gain
    input  wire gain_t i_kd,       // derivative gain
    output acc_t       o_out,      // compensator output
    output logic       o_done      // output valid pulse
);

    typedef struct packed {
        acc_t sum;
        acc_t prev;
        acc_t out;
        logic done;
    } pid_state_t;

    pid_state_t s_r;
    pid_state_t s_nxt;

    always_comb
    begin
        wide_t acc;
        acc_t  sum_new;
        acc_t  diff;
        s_nxt      = s_r;
        s_nxt.done = 1'b0;
        sum_new    = sat32(wide_t'(s_r.sum) + wide_t'(i_err));
        diff       = sat32(wide_t'(i_err) - wide_t'(s_r.prev));
        acc        = mul32(acc_t'(i_kp), i_err)
                   + mul32(acc_t'(i_ki), sum_new)
                   + mul32(acc_t'(i_kd), diff);
        if (i_start)
        begin
            s_nxt.sum  = sum_new;
            s_nxt.prev = i_err;
            s_nxt.out  = sat32(acc >>> GAIN_FRAC);
            s_nxt.done = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign o_out  = s_r.out;
    assign o_done = s_r.done;

endmodule : pid_core

// [test/pfc_rail_pid_loops_chk.sv]
// Purpose: port assertions for the rail and current loops
// Assumes: one clock domain, sync reset high
// Notes:   a gap counter checks evaluation spacing
`timescale 1ns/1ns
module pfc_rail_pid_loops_chk
    import pfc_loop_pkg::*;
#(
    parameter int unsigned SAMPLE_PERIOD_CYC = SAMPLE_CYCLES  // period
)
(
    input  wire logic  i_sys_clk,     // clock
    input  wire logic  i_sys_rst,     // reset
    input  wire samp_t o_duty,        // duty
    input  wire logic  o_duty_valid,  // duty pulse
    input  wire logic  o_sample_late, // late flag
    input  wire acc_t  o_rail_ctrl    // rail output
);
    logic [15:0] gap_r;
    logic [15:0] gap_nxt;

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_sys_rst);

    always_comb
    begin
        gap_nxt = (gap_r == 16'hFFFF) ? gap_r : gap_r + 16'h0001;
        if (o_duty_valid)
            gap_nxt = 16'h0001;
    end

    always_ff @(posedge i_sys_clk)
        gap_r <= i_sys_rst ? 16'hFFFF : gap_nxt;

    property p_duty_range;
        o_duty >= DUTY_MIN && o_duty <= DUTY_MAX;
    endproperty
    a_duty_range: assert property (p_duty_range)
        else $error("duty out of range");
    property p_valid_pulse;
        o_duty_valid |=> !o_duty_valid;
    endproperty
    a_valid_pulse: assert property (p_valid_pulse)
        else $error("duty pulse too long");
    property p_duty_hold;
        !o_duty_valid |-> $stable(o_duty);
    endproperty
    a_duty_hold: assert property (p_duty_hold)
        else $error("duty changed without pulse");
    property p_period;
        o_duty_valid |-> gap_r >= 16'(SAMPLE_PERIOD_CYC);
    endproperty
    a_period: assert property (p_period)
        else $error("two updates in one period");
    property p_late_quiet;
        $rose(o_sample_late) |-> !o_duty_valid [*8];
    endproperty
    a_late_quiet: assert property (p_late_quiet)
        else $error("update without fresh samples");
    property p_late_clear;
        o_duty_valid |=> !o_sample_late;
    endproperty
    a_late_clear: assert property (p_late_clear)
        else $error("late flag kept after update");
    property p_late_fall;
        $fell(o_sample_late) |-> ##[0:7] o_duty_valid;
    endproperty
    a_late_fall: assert property (p_late_fall)
        else $error("late flag cleared without update");
    property p_rail_lead;
        $changed(o_rail_ctrl) |-> ##4 o_duty_valid;
    endproperty
    a_rail_lead: assert property (p_rail_lead)
        else $error("rail output not followed by duty");

    c_update: cover property (o_duty_valid);
    c_late: cover property ($rose(o_sample_late));
    c_top: cover property (o_duty_valid && o_duty == DUTY_MAX);
endmodule : pfc_rail_pid_loops_chk

bind pfc_rail_pid_loops pfc_rail_pid_loops_chk #(
    .SAMPLE_PERIOD_CYC(SAMPLE_PERIOD_CYC)
) u_chk (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .o_duty(o_duty),
    .o_duty_valid(o_duty_valid), .o_sample_late(o_sample_late),
    .o_rail_ctrl(o_rail_ctrl)
);

// [test/pfc_sample_src.sv]
// Purpose: sample source beside the loop block
// Assumes: strobe slot lies well before the period tick
// Notes:   idle data lines show inverted values
`timescale 1ns/1ns
module pfc_sample_src
    import pfc_loop_pkg::*;
#(
    parameter int unsigned PERIOD = 20,  // clocks per period
    parameter int unsigned SLOT   = 10   // strobe slot
)
(
    input  wire logic  i_sys_clk,  // clock
    input  wire logic  i_sys_rst,  // reset
    input  wire logic  i_enable,   // send samples
    input  wire samp_t i_rail,     // rail to send
    input  wire samp_t i_line,     // line to send
    input  wire samp_t i_cur,      // current to send
    output logic       o_valid,    // strobe
    output samp_t      o_rail,     // rail sample
    output samp_t      o_line,     // line sample
    output samp_t      o_cur       // current sample
);
    int unsigned cnt = 0;
    logic        hit;

    assign hit = i_enable && !i_sys_rst && cnt == SLOT;

    always @(posedge i_sys_clk)
        cnt <= (i_sys_rst || cnt == PERIOD - 1) ? 0 : cnt + 1;

    initial {o_valid, o_rail, o_line, o_cur} = '0;
    // one fresh set per period, lines inverted outside the strobe
    always @(negedge i_sys_clk)
    begin
        o_valid <= hit;
        o_rail  <= hit ? i_rail : ~i_rail;
        o_line  <= hit ? i_line : ~i_line;
        o_cur   <= hit ? i_cur : ~i_cur;
    end
endmodule : pfc_sample_src

// [test/pfc_rail_pid_loops_test.sv]
// Purpose: self-checking bench for the rail and current loops
// Assumes: 20 clock sample period keeps the run short
// Notes:   a reference model tracks filter and integrator state
`timescale 1ns/1ns
module pfc_rail_pid_loops_test
    import pfc_loop_pkg::*;
;
`define CHECK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("mismatch %0t got %h exp %h", $time, got, exp); \
        end \
    end
    localparam int unsigned PER = 20;
    logic   i_sys_clk = 1'b0;
    logic   i_sys_rst = 1'b1;
    logic   en = 1'b1;
    logic   sv, duty_v, late, seen;
    samp_t  rail = '0, line = '0, cur = '0, sp = '0;
    samp_t  s_rail, s_line, s_cur, duty;
    acc_t   rctl;
    int     n_mismatch = 0, comparisons = 0;
    longint filt_m = 0, rsum = 0, csum = 0, rout, duty_e;
    samp_t  rows [6][4] = '{
        '{16'h4000, 16'h2000, 16'h1000, 16'h5000},
        '{16'h4000, 16'hE000, 16'h1000, 16'h5000},
        '{16'h4000, 16'h8000, 16'h4600, 16'h5000},
        '{16'h7FFF, 16'h2000, 16'h7FFF, 16'h0000},
        '{16'h0000, 16'h7FFF, 16'h8000, 16'h7FFF},
        '{16'h2000, 16'h1000, 16'h0800, 16'h3000}};

    pfc_sample_src #(.PERIOD(PER)) u_src (
        .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_enable(en),
        .i_rail(rail), .i_line(line), .i_cur(cur), .o_valid(sv),
        .o_rail(s_rail), .o_line(s_line), .o_cur(s_cur));
    pfc_rail_pid_loops #(.SAMPLE_PERIOD_CYC(PER)) uut (
        .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
        .i_sample_valid(sv), .i_rail_sample(s_rail),
        .i_line_sample(s_line), .i_cur_sample(s_cur),
        .i_rail_setpoint(sp), .o_duty(duty), .o_duty_valid(duty_v),
        .o_sample_late(late), .o_rail_ctrl(rctl));

    initial
    begin
        forever #5 i_sys_clk = ~i_sys_clk;
    end

    function automatic longint clip32(input longint v);
        if (v > ACC_MAX)
            return ACC_MAX;
        if (v < ACC_MIN)
            return ACC_MIN;
        return v;
    endfunction : clip32

    task automatic step;
        longint re, al, ce;
        filt_m = clip32((LPF_B0 * rail + LPF_A1 * filt_m) >>> GAIN_FRAC);
        re = sp - filt_m;
        rsum = clip32(rsum + re);
        rout = clip32((KP_RAIL * re + KI_RAIL * rsum) >>> GAIN_FRAC);
        al = (line < 0) ? -longint'(line) : longint'(line);
        if (al > SAMP_MAX)
            al = SAMP_MAX;
        ce = clip32(clip32((rout * al) >>> SAMP_FRAC) - cur);
        csum = clip32(csum + ce);
        duty_e = clip32((KP_CUR * ce + KI_CUR * csum) >>> GAIN_FRAC);
        if (duty_e < DUTY_MIN)
            duty_e = DUTY_MIN;
        if (duty_e > DUTY_MAX)
            duty_e = DUTY_MAX;
    endtask : step

    task automatic run;
        int n;
        n = 0;
        @(negedge i_sys_clk);
        while (duty_v !== 1'b1 && n < 3 * PER)
        begin
            @(negedge i_sys_clk);
            n++;
        end
        step;
        `CHECK(duty_v, 1'b1)
        `CHECK(rctl, acc_t'(rout))
        `CHECK(duty, samp_t'(duty_e))
    endtask : run

    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results

    initial
    begin
        repeat (50 * PER) @(posedge i_sys_clk);
        n_mismatch++;
        results;
    end

    initial
    begin
        repeat (10) @(negedge i_sys_clk);
        `CHECK({duty, duty_v, late, rctl}, 50'h0)
        i_sys_rst = 1'b0;
        for (int r = 0; r < 6; r++)
        begin
            {rail, line, cur, sp} = {rows[r][0], rows[r][1], rows[r][2],
                                     rows[r][3]};
            run;
        end
        $display("rows done");
        en = 1'b0;
        seen = 1'b0;
        repeat (2 * PER)
        begin
            @(negedge i_sys_clk);
            seen = seen | duty_v;
        end
        `CHECK({seen, late}, 2'b01)
        en = 1'b1;
        run;
        @(negedge i_sys_clk);
        `CHECK(late, 1'b0)
        $display("late done");
        i_sys_rst = 1'b1;
        repeat (10) @(negedge i_sys_clk);
        `CHECK({duty, duty_v, late, rctl}, 50'h0)
        {filt_m, rsum, csum} = '0;
        i_sys_rst = 1'b0;
        run;
        $display("reset done");
        results;
    end
endmodule : pfc_rail_pid_loops_test
